// file: rtl/cbto_defs.vh
// Constants for the bit, transfer and read-modify-write execution unit
`ifndef CBTO_DEFS_VH
`define CBTO_DEFS_VH

// Operation codes on the issue port
`define CBTO_OP_PMST 4'h0
`define CBTO_OP_IN 4'h1
`define CBTO_OP_OUT 4'h2
`define CBTO_OP_PUSH 4'h3
`define CBTO_OP_POP 4'h4
`define CBTO_OP_LOAD_OR 4'h5
`define CBTO_OP_LOAD_MASK 4'h6
`define CBTO_OP_LOAD_XOR 4'h7
`define CBTO_OP_ROT_UP 4'h8
`define CBTO_OP_ROT_DN 4'h9
`define CBTO_OP_IO_ONE 4'hA
`define CBTO_OP_IO_ZERO 4'hB
`define CBTO_OP_T_STORE 4'hC
`define CBTO_OP_T_LOAD 4'hD
`define CBTO_OP_FSET 4'hE
`define CBTO_OP_FCLR 4'hF

// Flag positions in the processor flag register
`define CBTO_F_C 0
`define CBTO_F_Z 1
`define CBTO_F_N 2
`define CBTO_F_V 3
`define CBTO_F_S 4
`define CBTO_F_H 5
`define CBTO_F_T 6
`define CBTO_F_I 7

// Register byte addresses on the bus
`define CBTO_ADR_FLAGS 8'h00
`define CBTO_ADR_ZPTR 8'h04
`define CBTO_ADR_SP 8'h08
`define CBTO_ADR_CTRL 8'h0C
`define CBTO_ADR_STAT 8'h10

// Control register fields
`define CBTO_CTRL_EXTWAIT 0
`define CBTO_CTRL_SRAMX 1

// Reset values
`define CBTO_FLAGS_RST 8'h00
`define CBTO_ZPTR_RST 24'h000000
`define CBTO_SP_RST 16'h0FFF
`define CBTO_CTRL_RST 2'h0

// Pointer steps
`define CBTO_Z_STEP 24'h000002
`define CBTO_SP_STEP 16'h0001

`endif

// file: rtl/cbto_exec.v
// Execution unit for bit, flag, transfer and read-modify-write operations
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`include "cbto_defs.vh"

module cbto_exec
(
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Issue port
  input wire op_valid_i,
  input wire [3:0] op_code_i,
  input wire [7:0] op_reg_i,
  input wire [15:0] op_r1r0_i,
  input wire [2:0] op_bit_i,
  input wire [5:0] op_io_addr_i,
  output wire op_ready_o,
  output reg op_done_o,
  output reg res_valid_o,
  output reg [7:0] res_data_o,
  // Data memory
  output reg [15:0] dm_addr_o,
  output reg [7:0] dm_wdata_o,
  output reg dm_we_o,
  output reg dm_re_o,
  input wire [7:0] dm_rdata_i,
  input wire dm_ack_i,
  // I/O register space
  output reg [5:0] io_addr_o,
  output reg [7:0] io_wdata_o,
  output reg [7:0] io_wmask_o,
  output reg io_we_o,
  output reg io_re_o,
  input wire [7:0] io_rdata_i,
  // Program memory store
  output reg [23:0] pm_addr_o,
  output reg [15:0] pm_data_o,
  output reg pm_req_o,
  input wire pm_done_i,
  // Flag register view
  output wire [7:0] flags_o
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_EXEC = 3'd1;
  localparam [2:0] S_MEMWR = 3'd2;
  localparam [2:0] S_SPINC = 3'd3;
  localparam [2:0] S_RDX = 3'd4;
  localparam [2:0] S_RD = 3'd5;
  localparam [2:0] S_PM = 3'd6;

  reg [2:0] state_reg;
  reg [3:0] op_reg;
  reg [7:0] opnd_reg;
  reg [2:0] bit_reg;
  reg [7:0] flags_reg;
  reg [23:0] zptr_reg;
  reg [15:0] sp_reg;
  reg [1:0] ctrl_reg;
  reg [7:0] rot_next;
  reg [7:0] rmw_next;
  reg [7:0] bitmask;
  wire mem_ready;
  wire bus_wr;
  wire bus_req;

  assign op_ready_o = (state_reg == S_IDLE);
  assign flags_o = flags_reg;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  // Internal memory completes at once, external waits for acknowledge
  assign mem_ready = ~ctrl_reg[`CBTO_CTRL_EXTWAIT] | dm_ack_i;

  // Rotate result and one-hot bit mask
  // Carry comes from the flag register as it stands in the execute cycle, one cycle after the op was taken
  always @*
  begin
    bitmask = 8'h01 << bit_reg;
    if (op_reg == `CBTO_OP_ROT_UP)
      rot_next = {opnd_reg[6:0], flags_reg[`CBTO_F_C]};
    else
      rot_next = {flags_reg[`CBTO_F_C], opnd_reg[7:1]};
  end

  // Write-back value for read-modify-write, from old register and old byte
  // Built from the read data while the read strobe stands, so the write
  // data is final in the very first write cycle; a memory that takes the
  // write at once never sees a stale byte
  always @*
  begin
    case (op_reg)
      `CBTO_OP_LOAD_OR: rmw_next = opnd_reg | dm_rdata_i;
      `CBTO_OP_LOAD_MASK: rmw_next = ~opnd_reg & dm_rdata_i;
      default: rmw_next = opnd_reg ^ dm_rdata_i;
    endcase
  end

  // Bus acknowledge one cycle after the request, dropped the cycle after
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      case (wb_adr_i)
        `CBTO_ADR_FLAGS: wb_dat_o <= {24'h000000, flags_reg};
        `CBTO_ADR_ZPTR: wb_dat_o <= {8'h00, zptr_reg};
        `CBTO_ADR_SP: wb_dat_o <= {16'h0000, sp_reg};
        `CBTO_ADR_CTRL: wb_dat_o <= {30'h00000000, ctrl_reg};
        `CBTO_ADR_STAT: wb_dat_o <= {24'h000000, op_reg, 1'b0, state_reg};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Sequencer, datapath and software-visible state
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= S_IDLE;
      op_reg <= 4'h0;
      opnd_reg <= 8'h00;
      bit_reg <= 3'h0;
      flags_reg <= `CBTO_FLAGS_RST;
      zptr_reg <= `CBTO_ZPTR_RST;
      sp_reg <= `CBTO_SP_RST;
      ctrl_reg <= `CBTO_CTRL_RST;
      op_done_o <= 1'b0;
      res_valid_o <= 1'b0;
      res_data_o <= 8'h00;
      dm_addr_o <= 16'h0000;
      dm_wdata_o <= 8'h00;
      dm_we_o <= 1'b0;
      dm_re_o <= 1'b0;
      io_addr_o <= 6'h00;
      io_wdata_o <= 8'h00;
      io_wmask_o <= 8'h00;
      io_we_o <= 1'b0;
      io_re_o <= 1'b0;
      pm_addr_o <= 24'h000000;
      pm_data_o <= 16'h0000;
      pm_req_o <= 1'b0;
    end
    else
    begin
      op_done_o <= 1'b0;
      res_valid_o <= 1'b0;
      // Software writes; an instruction update below in the same cycle wins
      if (bus_wr)
      begin
        if (wb_adr_i == `CBTO_ADR_FLAGS && wb_sel_i[0])
          flags_reg <= wb_dat_i[7:0];
        if (wb_adr_i == `CBTO_ADR_ZPTR)
        begin
          if (wb_sel_i[0])
            zptr_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            zptr_reg[15:8] <= wb_dat_i[15:8];
          if (wb_sel_i[2])
            zptr_reg[23:16] <= wb_dat_i[23:16];
        end
        if (wb_adr_i == `CBTO_ADR_SP)
        begin
          if (wb_sel_i[0])
            sp_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            sp_reg[15:8] <= wb_dat_i[15:8];
        end
        if (wb_adr_i == `CBTO_ADR_CTRL && wb_sel_i[0])
          ctrl_reg <= wb_dat_i[1:0];
      end
      case (state_reg)
        S_IDLE:
        begin
          if (op_valid_i)
          begin
            op_reg <= op_code_i;
            opnd_reg <= op_reg_i;
            bit_reg <= op_bit_i;
            state_reg <= S_EXEC;
            case (op_code_i)
              `CBTO_OP_PMST:
              begin
                pm_req_o <= 1'b1;
                pm_addr_o <= zptr_reg;
                pm_data_o <= op_r1r0_i;
                state_reg <= S_PM;
              end
              `CBTO_OP_IN:
              begin
                io_re_o <= 1'b1;
                io_addr_o <= op_io_addr_i;
              end
              `CBTO_OP_OUT:
              begin
                io_we_o <= 1'b1;
                io_addr_o <= op_io_addr_i;
                io_wdata_o <= op_reg_i;
                io_wmask_o <= 8'hFF;
              end
              `CBTO_OP_IO_ONE, `CBTO_OP_IO_ZERO:
              begin
                io_we_o <= 1'b1;
                io_addr_o <= op_io_addr_i;
                // Only the masked bit is written, others keep their value
                // No read is needed, so the whole op fits in one cycle
                io_wmask_o <= 8'h01 << op_bit_i;
                io_wdata_o <= (op_code_i == `CBTO_OP_IO_ONE) ? 8'hFF : 8'h00;
              end
              `CBTO_OP_PUSH:
              begin
                dm_we_o <= 1'b1;
                dm_addr_o <= sp_reg;
                dm_wdata_o <= op_reg_i;
                sp_reg <= sp_reg - `CBTO_SP_STEP;
                state_reg <= S_MEMWR;
              end
              `CBTO_OP_POP:
              begin
                sp_reg <= sp_reg + `CBTO_SP_STEP;
                state_reg <= S_SPINC;
              end
              `CBTO_OP_LOAD_OR, `CBTO_OP_LOAD_MASK, `CBTO_OP_LOAD_XOR:
              begin
                // Read the old byte at Z first, the write follows
                dm_re_o <= 1'b1;
                dm_addr_o <= zptr_reg[15:0];
                state_reg <= ctrl_reg[`CBTO_CTRL_SRAMX] ? S_RDX : S_RD;
              end
              default: state_reg <= S_EXEC;
            endcase
          end
        end
        S_EXEC:
        begin
          io_re_o <= 1'b0;
          io_we_o <= 1'b0;
          op_done_o <= 1'b1;
          state_reg <= S_IDLE;
          case (op_reg)
            `CBTO_OP_IN:
            begin
              res_data_o <= io_rdata_i;
              res_valid_o <= 1'b1;
            end
            `CBTO_OP_ROT_UP:
            begin
              // Half carry takes the old bit 3, as for a shift by one
              res_data_o <= rot_next;
              res_valid_o <= 1'b1;
              flags_reg[`CBTO_F_C] <= opnd_reg[7];
              flags_reg[`CBTO_F_Z] <= (rot_next == 8'h00);
              flags_reg[`CBTO_F_N] <= rot_next[7];
              flags_reg[`CBTO_F_V] <= rot_next[7] ^ opnd_reg[7];
              flags_reg[`CBTO_F_H] <= opnd_reg[3];
            end
            `CBTO_OP_ROT_DN:
            begin
              res_data_o <= rot_next;
              res_valid_o <= 1'b1;
              flags_reg[`CBTO_F_C] <= opnd_reg[0];
              flags_reg[`CBTO_F_Z] <= (rot_next == 8'h00);
              flags_reg[`CBTO_F_N] <= rot_next[7];
              flags_reg[`CBTO_F_V] <= rot_next[7] ^ opnd_reg[0];
            end
            `CBTO_OP_T_STORE: flags_reg[`CBTO_F_T] <= |(opnd_reg & bitmask);
            `CBTO_OP_T_LOAD:
            begin
              // Copy T into the selected bit, flags stay as they are
              res_data_o <= flags_reg[`CBTO_F_T] ? (opnd_reg | bitmask)
                : (opnd_reg & ~bitmask);
              res_valid_o <= 1'b1;
            end
            // Any single flag by index, so V, H and S each stand alone
            `CBTO_OP_FSET: flags_reg <= flags_reg | bitmask;
            `CBTO_OP_FCLR: flags_reg <= flags_reg & ~bitmask;
            default: res_valid_o <= 1'b0;
          endcase
        end
        S_SPINC:
        begin
          // Stack read at the incremented pointer
          dm_re_o <= 1'b1;
          dm_addr_o <= sp_reg;
          state_reg <= ctrl_reg[`CBTO_CTRL_SRAMX] ? S_RDX : S_RD;
        end
        S_RDX: state_reg <= S_RD;
        S_RD:
        begin
          if (mem_ready)
          begin
            dm_re_o <= 1'b0;
            res_data_o <= dm_rdata_i;
            res_valid_o <= 1'b1;
            if (op_reg == `CBTO_OP_POP)
            begin
              op_done_o <= 1'b1;
              state_reg <= S_IDLE;
            end
            else
            begin
              // Write data set together with the strobe, never after it
              // Address stays at Z from the read
              dm_we_o <= 1'b1;
              dm_wdata_o <= rmw_next;
              state_reg <= S_MEMWR;
            end
          end
        end
        S_MEMWR:
        begin
          // Write data is already final; hold it until the memory answers
          // An external memory may take several cycles, the strobe stays up
          if (mem_ready)
          begin
            dm_we_o <= 1'b0;
            op_done_o <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        S_PM:
        begin
          // Wait for the nonvolatile controller, no fixed count
          // Z only moves once the word is known to be stored
          if (pm_done_i)
          begin
            pm_req_o <= 1'b0;
            zptr_reg <= zptr_reg + `CBTO_Z_STEP;
            op_done_o <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

// file: tb/cbto_exec_properties.sv
// Port assertions for the bit, transfer and read-modify-write unit
`include "cbto_defs.vh"
module cbto_exec_props
(
  input wire clk_i,
  input wire rst_i,
  input wire op_valid_i,
  input wire [3:0] op_code_i,
  input wire [7:0] op_reg_i,
  input wire [15:0] op_r1r0_i,
  input wire [2:0] op_bit_i,
  input wire op_ready_o,
  input wire res_valid_o,
  input wire [7:0] res_data_o,
  input wire dm_we_o,
  input wire [7:0] dm_wdata_o,
  input wire io_we_o,
  input wire [7:0] io_wdata_o,
  input wire [7:0] io_wmask_o,
  input wire pm_req_o,
  input wire [15:0] pm_data_o,
  input wire pm_done_i,
  input wire [7:0] flags_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Acceptance and the selected source bit
  wire tk = op_valid_i & op_ready_o;
  wire bsel = op_reg_i[op_bit_i];
  chk_push_write: assert property (tk && op_code_i == `CBTO_OP_PUSH
    |=> dm_we_o && dm_wdata_o == $past(op_reg_i)) else $error("push data wrong");
  chk_force_one: assert property (tk && op_code_i == `CBTO_OP_IO_ONE
    |=> io_we_o && io_wdata_o == 8'hFF && io_wmask_o == 8'h01 << $past(op_bit_i))
    else $error("io bit set wrong");
  chk_force_zero: assert property (tk && op_code_i == `CBTO_OP_IO_ZERO
    |=> io_we_o && io_wdata_o == 8'h00 && io_wmask_o == 8'h01 << $past(op_bit_i))
    else $error("io bit clear wrong");
  chk_rotate_up: assert property (tk && op_code_i == `CBTO_OP_ROT_UP
    |=> ##1 res_valid_o && res_data_o == {$past(op_reg_i[6:0], 2), $past(flags_o[0], 2)}
    && flags_o[0] == $past(op_reg_i[7], 2)) else $error("rotate up wrong");
  chk_rotate_down: assert property (tk && op_code_i == `CBTO_OP_ROT_DN
    |=> ##1 res_valid_o && res_data_o == {$past(flags_o[0], 2), $past(op_reg_i[7:1], 2)}
    && flags_o[0] == $past(op_reg_i[0], 2)) else $error("rotate down wrong");
  chk_transfer_flag: assert property (tk && op_code_i == `CBTO_OP_T_STORE
    |=> ##1 flags_o[6] == $past(bsel, 2) && flags_o[5:0] == $past(flags_o[5:0], 2))
    else $error("bit store wrong");
  chk_flag_raise: assert property (tk && op_code_i == `CBTO_OP_FSET
    |=> ##1 flags_o == ($past(flags_o, 2) | 8'h01 << $past(op_bit_i, 2)))
    else $error("flag set wrong");
  chk_store_hold: assert property (pm_req_o && !pm_done_i |=> pm_req_o)
    else $error("store request dropped");
  chk_store_word: assert property (tk && op_code_i == `CBTO_OP_PMST
    |=> pm_req_o && pm_data_o == $past(op_r1r0_i)) else $error("store word wrong");
endmodule
bind cbto_exec cbto_exec_props u_cbto_exec_props (.*);

// file: tb/cbto_mem_model.sv
// Data memory, I/O space and program store seen by the unit
module cbto_mem_model
(
  input wire clk_i,
  input wire [1:0] lag_i,
  input wire [15:0] dm_addr_i,
  input wire [7:0] dm_wdata_i,
  input wire dm_we_i,
  input wire dm_re_i,
  output wire [7:0] dm_rdata_o,
  output wire dm_ack_o,
  input wire [5:0] io_addr_i,
  input wire [7:0] io_wdata_i,
  input wire [7:0] io_wmask_i,
  input wire io_we_i,
  input wire io_re_i,
  output wire [7:0] io_rdata_o,
  input wire [23:0] pm_addr_i,
  input wire [15:0] pm_data_i,
  input wire pm_req_i,
  output wire pm_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] dmem [0:4095];
  logic [7:0] io [0:63];
  logic [15:0] pm_word;
  logic [23:0] pm_at;
  logic [1:0] wait_cnt = 2'h0;
  // In-cycle reads; unselected lines show inverted data
  assign dm_rdata_o = dm_re_i ? dmem[dm_addr_i[11:0]] : ~dmem[dm_addr_i[11:0]];
  assign io_rdata_o = io_re_i ? io[io_addr_i] : ~io[io_addr_i];
  // Answers after lag_i waiting cycles
  assign dm_ack_o = (dm_we_i | dm_re_i) && wait_cnt == lag_i;
  assign pm_done_o = pm_req_i && wait_cnt == lag_i;
  // Storage updates and wait count
  always @(posedge clk_i)
  begin
    wait_cnt <= (dm_we_i | dm_re_i | pm_req_i) && wait_cnt != lag_i ? wait_cnt + 2'h1 : 2'h0;
    if (dm_we_i)
      dmem[dm_addr_i[11:0]] <= dm_wdata_i;
    if (io_we_i)
      io[io_addr_i] <= (io[io_addr_i] & ~io_wmask_i) | (io_wdata_i & io_wmask_i);
    if (pm_done_o)
      pm_word <= pm_data_i;
    if (pm_done_o)
      pm_at <= pm_addr_i;
  end
endmodule

// file: tb/cbto_exec_test.sv
// Self-checking bench for the bit, transfer and read-modify-write unit
`include "cbto_defs.vh"
module cbto_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, op_valid_i = 0;
  logic [7:0] wb_adr_i = 0, op_reg_i = 0, res_data_o, res_seen, io_rdata_i, dm_rdata_i;
  logic [7:0] dm_wdata_o, io_wdata_o, io_wmask_o, flags_o;
  logic [3:0] wb_sel_i = 4'hF, op_code_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic [15:0] op_r1r0_i = 0, dm_addr_o, pm_data_o;
  logic [2:0] op_bit_i = 0;
  logic [5:0] op_io_addr_i = 0, io_addr_o;
  logic [23:0] pm_addr_o;
  logic [1:0] lag = 0;
  logic wb_ack_o, op_ready_o, op_done_o, res_valid_o, dm_we_o, dm_re_o, dm_ack_i;
  logic io_we_o, io_re_o, pm_req_o, pm_done_i;
  logic [3:0] rm_c [4] = '{`CBTO_OP_LOAD_OR, `CBTO_OP_LOAD_MASK, `CBTO_OP_LOAD_XOR,
    `CBTO_OP_LOAD_MASK};
  logic [7:0] rm_r [4] = '{8'h0F, 8'h03, 8'hFF, 8'h30};
  logic [7:0] rm_m [5] = '{8'hC3, 8'hCF, 8'hCC, 8'h33, 8'h03};
  int error_cnt = 0, n_compared = 0;
  cbto_exec u_cbto_exec (.*);
  cbto_mem_model u_cbto_mem_model (.clk_i(clk_i), .lag_i(lag), .dm_addr_i(dm_addr_o),
    .dm_wdata_i(dm_wdata_o), .dm_we_i(dm_we_o), .dm_re_i(dm_re_o), .dm_rdata_o(dm_rdata_i),
    .dm_ack_o(dm_ack_i), .io_addr_i(io_addr_o), .io_wdata_i(io_wdata_o),
    .io_wmask_i(io_wmask_o), .io_we_i(io_we_o), .io_re_i(io_re_o), .io_rdata_o(io_rdata_i),
    .pm_addr_i(pm_addr_o), .pm_data_i(pm_data_o), .pm_req_i(pm_req_o), .pm_done_o(pm_done_i));
  always #50 clk_i = ~clk_i;
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'h1 && ++n < 40);
    chk("bus ack", wb_ack_o, 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask
  // Issue one operation and wait for its completion
  task automatic op(input logic [3:0] c, input logic [7:0] r, input logic [2:0] b);
    int n = 0;
    op_code_i <= c;
    op_reg_i <= r;
    op_bit_i <= b;
    op_valid_i <= 1'h1;
    @(posedge clk_i);
    op_valid_i <= 1'h0;
    do
    begin
      @(posedge clk_i);
      if (res_valid_o === 1'h1)
        res_seen = res_data_o;
    end
    while (op_done_o !== 1'h1 && ++n < 40);
    chk("op done", op_done_o, 1'h1);
    @(posedge clk_i);
  endtask
  // Watchdog far beyond the expected run
  initial
  begin
    #2000000;
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rd(`CBTO_ADR_SP, 32'h0FFF);
    rd(`CBTO_ADR_FLAGS, 32'h0);
    rd(8'h20, 32'h0);
    wr(`CBTO_ADR_ZPTR, 32'h010040);
    lag <= 2'h2;
    op_r1r0_i <= 16'hBEEF;
    op_io_addr_i <= 6'h05;
    op(`CBTO_OP_PMST, 8'h0, 3'h0);
    chk("pm word", u_cbto_mem_model.pm_word, 16'hBEEF);
    chk("pm addr", u_cbto_mem_model.pm_at, 24'h010040);
    rd(`CBTO_ADR_ZPTR, 32'h010042);
    op(`CBTO_OP_OUT, 8'h5A, 3'h0);
    op(`CBTO_OP_IN, 8'h0, 3'h0);
    chk("in data", res_seen, 8'h5A);
    op(`CBTO_OP_IO_ONE, 8'h0, 3'h0);
    chk("io set", u_cbto_mem_model.io[5], 8'h5B);
    op(`CBTO_OP_IO_ZERO, 8'h0, 3'h6);
    chk("io clear", u_cbto_mem_model.io[5], 8'h1B);
    op(`CBTO_OP_PUSH, 8'h3C, 3'h0);
    chk("stack byte", u_cbto_mem_model.dmem[12'hFFF], 8'h3C);
    rd(`CBTO_ADR_SP, 32'h0FFE);
    op(`CBTO_OP_POP, 8'h0, 3'h0);
    chk("pop data", res_seen, 8'h3C);
    rd(`CBTO_ADR_SP, 32'h0FFF);
    wr(`CBTO_ADR_ZPTR, 32'h10);
    u_cbto_mem_model.dmem[16] = 8'hC3;
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        wr(`CBTO_ADR_CTRL, 32'h3);
      op(rm_c[i], rm_r[i], 3'h0);
      chk("rmw old", res_seen, rm_m[i]);
      chk("rmw new", u_cbto_mem_model.dmem[16], rm_m[i + 1]);
    end
    for (int b = 3; b < 6; b++)
    begin
      wr(`CBTO_ADR_FLAGS, 32'hC7);
      op(`CBTO_OP_FSET, 8'h0, b[2:0]);
      chk("flag set", flags_o, 8'hC7 | 8'h01 << b);
      op(`CBTO_OP_FCLR, 8'h0, b[2:0]);
      chk("flag clear", flags_o, 8'hC7);
    end
    wr(`CBTO_ADR_FLAGS, 32'h1);
    op(`CBTO_OP_ROT_UP, 8'h80, 3'h0);
    chk("rotate up data", res_seen, 8'h01);
    chk("rotate up flags", flags_o, 8'h09);
    wr(`CBTO_ADR_FLAGS, 32'h0);
    op(`CBTO_OP_ROT_DN, 8'h01, 3'h0);
    chk("rotate down data", res_seen, 8'h00);
    chk("rotate down flags", flags_o, 8'h0B);
    wr(`CBTO_ADR_FLAGS, 32'h0);
    op(`CBTO_OP_T_STORE, 8'h10, 3'h4);
    chk("t store flags", flags_o, 8'h40);
    op(`CBTO_OP_T_LOAD, 8'h00, 3'h2);
    chk("t load data", res_seen, 8'h04);
    chk("t load flags", flags_o, 8'h40);
    print_verdict();
  end
endmodule
